// >>> logic/drs_top.sv
// Run/stop sequencer with AXI4-Lite register slave.
// Assumes run terminals are asynchronous pins; SPEED_FB is on CLOCK.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "drs_regs.svh"
module drs_top
   import drs_pkg::*;
#(
   parameter int TICK_CYCLES = `DRS_TICK_CYCLES
) (
   input  wire logic        CLOCK,
   input  wire logic        RST_N,
   input  wire logic [7:0]  AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   input  wire logic [7:0]  ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   input  wire logic        RUN_FWD,
   input  wire logic        RUN_REV,
   input  wire logic [15:0] SPEED_FB,
   output logic [15:0]      FREQ_CMD,
   output logic             DIR_REV,
   output logic             OUTPUT_ON,
   output logic             SLEEPING
);

   // Terminal synchroniser, bit 0 forward, bit 1 reverse
   logic [1:0] s1_q, s2_q, s3_q, term_q, term_d;

   always_comb begin
      term_d = term_q;
      if (s2_q == s3_q) begin
         term_d = s2_q;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         s1_q   <= 2'h0;
         s2_q   <= 2'h0;
         s3_q   <= 2'h0;
         term_q <= 2'h0;
      end else begin
         s1_q   <= {RUN_REV, RUN_FWD};
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         term_q <= term_d;
      end
   end

   // Register bus
   drs_cfg_t    cfg_q, cfg_d;
   logic [15:0] dead_q, dead_d, thr_q, thr_d, stt_q, stt_d;
   logic [15:0] wake_q, wake_d, rst_q, rst_d, slp_q, slp_d;
   logic [15:0] set_q, set_d, low_q, low_d, stf_q, stf_d;
   logic        awf_q, awf_d, wf_q, wf_d;
   logic [7:0]  awa_q, awa_d;
   logic [31:0] wd_q, wd_d;
   logic [3:0]  ws_q, ws_d;
   logic        awr_q, awr_d, wr_q, wr_d, bv_q, bv_d;
   logic [1:0]  br_q, br_d, rr_q, rr_d;
   logic        arr_q, arr_d, rv_q, rv_d;
   logic [31:0] rd_q, rd_d;
   drs_state_t  st_q, st_d;
   logic        dir_q, on_q, slp_o_q;
   logic [15:0] freq_q;

   function automatic logic mapped(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= `DRS_A_STATUS);
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
      return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
   endfunction

   always_comb begin
      cfg_d  = cfg_q;
      dead_d = dead_q;
      thr_d  = thr_q;
      stt_d  = stt_q;
      wake_d = wake_q;
      rst_d  = rst_q;
      slp_d  = slp_q;
      set_d  = set_q;
      low_d  = low_q;
      stf_d  = stf_q;
      awf_d  = awf_q;
      awa_d  = awa_q;
      wf_d   = wf_q;
      wd_d   = wd_q;
      ws_d   = ws_q;
      bv_d   = bv_q;
      br_d   = br_q;
      rv_d   = rv_q;
      rr_d   = rr_q;
      rd_d   = rd_q;
      if (AWVALID && awr_q) begin
         awf_d = 1'b1;
         awa_d = AWADDR;
      end
      if (WVALID && wr_q) begin
         wf_d = 1'b1;
         wd_d = WDATA;
         ws_d = WSTRB;
      end
      if (bv_q && BREADY) begin
         bv_d = 1'b0;
      end
      // Write once both halves are held and no response is pending
      if (awf_q && wf_q && !bv_q) begin
         awf_d = 1'b0;
         wf_d  = 1'b0;
         bv_d  = 1'b1;
         br_d  = mapped(awa_q) ? 2'h0 : 2'h2;
         unique case (awa_q)
            `DRS_A_CFG: begin
               cfg_d = drs_cfg_t'(11'(merge({5'h00, cfg_q}, wd_q, ws_q)));
            end
            `DRS_A_DEADZONE:  dead_d = merge(dead_q, wd_q, ws_q);
            `DRS_A_STOP_THR:  thr_d  = merge(thr_q, wd_q, ws_q);
            `DRS_A_STOP_TIME: stt_d  = merge(stt_q, wd_q, ws_q);
            `DRS_A_WAKE:      wake_d = merge(wake_q, wd_q, ws_q);
            `DRS_A_RESTART:   rst_d  = merge(rst_q, wd_q, ws_q);
            `DRS_A_SLEEP:     slp_d  = merge(slp_q, wd_q, ws_q);
            `DRS_A_SET_FREQ:  set_d  = merge(set_q, wd_q, ws_q);
            `DRS_A_LOW_LIM:   low_d  = merge(low_q, wd_q, ws_q);
            `DRS_A_START_F:   stf_d  = merge(stf_q, wd_q, ws_q);
            default: ;
         endcase
      end
      if (rv_q && RREADY) begin
         rv_d = 1'b0;
      end
      if (ARVALID && arr_q) begin
         rv_d = 1'b1;
         rr_d = mapped(ARADDR) ? 2'h0 : 2'h2;
         unique case (ARADDR)
            `DRS_A_CFG:       rd_d = {21'h0, cfg_q};
            `DRS_A_DEADZONE:  rd_d = {16'h0, dead_q};
            `DRS_A_STOP_THR:  rd_d = {16'h0, thr_q};
            `DRS_A_STOP_TIME: rd_d = {16'h0, stt_q};
            `DRS_A_WAKE:      rd_d = {16'h0, wake_q};
            `DRS_A_RESTART:   rd_d = {16'h0, rst_q};
            `DRS_A_SLEEP:     rd_d = {16'h0, slp_q};
            `DRS_A_SET_FREQ:  rd_d = {16'h0, set_q};
            `DRS_A_LOW_LIM:   rd_d = {16'h0, low_q};
            `DRS_A_START_F:   rd_d = {16'h0, stf_q};
            `DRS_A_STATUS: begin
               rd_d = {freq_q, 7'h00, term_q, slp_o_q, on_q, dir_q, st_q};
            end
            default:          rd_d = 32'h0000_0000;
         endcase
      end
      awr_d = !awf_d;
      wr_d  = !wf_d;
      arr_d = !rv_d;
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         cfg_q  <= drs_cfg_t'(`DRS_R_CFG);
         dead_q <= `DRS_R_DEADZONE;
         thr_q  <= `DRS_R_STOP_THR;
         stt_q  <= `DRS_R_STOP_TIME;
         wake_q <= `DRS_R_WAKE;
         rst_q  <= `DRS_R_RESTART;
         slp_q  <= `DRS_R_SLEEP;
         set_q  <= `DRS_R_ZERO16;
         low_q  <= `DRS_R_ZERO16;
         stf_q  <= `DRS_R_ZERO16;
         awf_q  <= 1'b0;
         awa_q  <= 8'h00;
         wf_q   <= 1'b0;
         wd_q   <= 32'h0000_0000;
         ws_q   <= 4'h0;
         awr_q  <= 1'b0;
         wr_q   <= 1'b0;
         bv_q   <= 1'b0;
         br_q   <= 2'h0;
         arr_q  <= 1'b0;
         rv_q   <= 1'b0;
         rr_q   <= 2'h0;
         rd_q   <= 32'h0000_0000;
      end else begin
         cfg_q  <= cfg_d;
         dead_q <= dead_d;
         thr_q  <= thr_d;
         stt_q  <= stt_d;
         wake_q <= wake_d;
         rst_q  <= rst_d;
         slp_q  <= slp_d;
         set_q  <= set_d;
         low_q  <= low_d;
         stf_q  <= stf_d;
         awf_q  <= awf_d;
         awa_q  <= awa_d;
         wf_q   <= wf_d;
         wd_q   <= wd_d;
         ws_q   <= ws_d;
         awr_q  <= awr_d;
         wr_q   <= wr_d;
         bv_q   <= bv_d;
         br_q   <= br_d;
         arr_q  <= arr_d;
         rv_q   <= rv_d;
         rr_q   <= rr_d;
         rd_q   <= rd_d;
      end
   end

   assign AWREADY = awr_q;
   assign WREADY  = wr_q;
   assign BVALID  = bv_q;
   assign BRESP   = br_q;
   assign ARREADY = arr_q;
   assign RVALID  = rv_q;
   assign RRESP   = rr_q;
   assign RDATA   = rd_q;

   // Sequencer, tick base and shared delay timer
   logic [17:0] tc_q, tc_d;
   logic        tick_q, tick_d;
   logic [19:0] tm_q, tm_d, lim;
   // Init outlasts the terminal synchroniser and a first config write
   logic [2:0]  init_q, init_d;
   logic        dir_d, on_d, slp_o_d, cond, cmd_run, cmd_rev;
   logic        below, above, expired;
   logic [15:0] freq_d, spd, sw_lvl;

   always_comb begin
      tick_d  = (tc_q == 18'(TICK_CYCLES - 1));
      tc_d    = tick_d ? 18'h00000 : tc_q + 18'h00001;
      init_d  = (init_q == `DRS_INIT_CYCLES) ? init_q : init_q + 3'h1;
      cmd_run = cfg_q.term_ctrl ? |term_q : cfg_q.soft_run;
      cmd_rev = cfg_q.term_ctrl ? term_q[1] : cfg_q.soft_rev;
      // Measured speed not trusted in open-loop vector modulation
      spd     = (cfg_q.src_sel && !cfg_q.ovm) ? SPEED_FB : freq_q;
      below   = set_q < low_q;
      above   = set_q > low_q;
      sw_lvl  = (cfg_q.sw_sel == 2'h1) ? stf_q : 16'h0000;
      // Limit settled before the expiry test reads it
      unique case (st_q)
         S_RESTART_WAIT: lim = {4'h0, rst_q} * `DRS_TENTH_TICKS;
         S_REV_HOLD:     lim = {4'h0, stt_q};
         S_DEADZONE:     lim = {4'h0, dead_q} * `DRS_TENTH_TICKS;
         S_SLEEP_PEND:   lim = {4'h0, slp_q} * `DRS_TENTH_TICKS;
         S_SLEEP:        lim = {4'h0, wake_q} * `DRS_TENTH_TICKS;
         default:        lim = 20'h00000;
      endcase
      expired = tm_q >= lim;
      st_d    = st_q;
      dir_d   = dir_q;
      freq_d  = 16'h0000;
      cond    = 1'b1;
      unique case (st_q)
         S_INIT: begin
            if (init_q == `DRS_INIT_CYCLES) begin
               if (cfg_q.restart_en && cmd_run) begin
                  st_d = S_RESTART_WAIT;
               end else if (cmd_run && cfg_q.term_ctrl && !cfg_q.protect) begin
                  st_d = S_PROTECT;
               end else if (cmd_run) begin
                  st_d = S_RUN;
               end else begin
                  st_d = S_STOP;
               end
               dir_d = cmd_rev;
            end
         end
         S_RESTART_WAIT: begin
            cond = cmd_run;
            if (!cmd_run) begin
               st_d = S_STOP;
            end else if (expired) begin
               st_d = S_RUN;
            end
         end
         S_PROTECT: begin
            if (!cmd_run) begin
               st_d = S_STOP;
            end
         end
         S_STOP: begin
            dir_d = cmd_rev;
            if (cmd_run) begin
               st_d = S_RUN;
            end
         end
         S_RUN: begin
            freq_d = set_q;
            if (!cmd_run) begin
               st_d = S_STOP;
            end else if (cmd_rev != dir_q) begin
               st_d = S_REV_HOLD;
            end else if (below) begin
               unique case (cfg_q.lim_act)
                  2'h0: freq_d = low_q;
                  2'h1: st_d = S_LIM_STOP;
                  default: st_d = S_SLEEP_PEND;
               endcase
            end
         end
         S_REV_HOLD: begin
            freq_d = sw_lvl;
            cond   = spd < thr_q;
            if (!cmd_run) begin
               st_d = S_STOP;
            end else if (cmd_rev == dir_q) begin
               st_d = S_RUN;
            end else if (cfg_q.sw_sel != 2'h2 || (cond && expired)) begin
               st_d = S_DEADZONE;
            end
         end
         S_DEADZONE: begin
            freq_d = sw_lvl;
            if (!cmd_run) begin
               st_d = S_STOP;
            end else if (expired) begin
               dir_d = cmd_rev;
               st_d  = S_RUN;
            end
         end
         S_LIM_STOP: begin
            if (!cmd_run) begin
               st_d = S_STOP;
            end else if (!below) begin
               st_d = S_RUN;
            end
         end
         S_SLEEP_PEND: begin
            freq_d = low_q;
            cond   = below;
            if (!cmd_run) begin
               st_d = S_STOP;
            end else if (!below) begin
               st_d = S_RUN;
            end else if (expired) begin
               st_d = S_SLEEP;
            end
         end
         S_SLEEP: begin
            cond = above;
            if (!cmd_run) begin
               st_d = S_STOP;
            end else if (above && expired) begin
               st_d = S_RUN;
            end
         end
      endcase
      on_d    = st_d inside {S_RUN, S_REV_HOLD, S_DEADZONE, S_SLEEP_PEND};
      slp_o_d = st_d == S_SLEEP;
      if (!on_d) begin
         freq_d = 16'h0000;
      end
      // Timer restarts on a new state or a lost condition
      if (st_d != st_q || !cond) begin
         tm_d = 20'h00000;
      end else if (tick_q && !expired) begin
         tm_d = tm_q + 20'h00001;
      end else begin
         tm_d = tm_q;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         tc_q    <= 18'h00000;
         tick_q  <= 1'b0;
         tm_q    <= 20'h00000;
         init_q  <= 3'h0;
         st_q    <= S_INIT;
         dir_q   <= 1'b0;
         on_q    <= 1'b0;
         slp_o_q <= 1'b0;
         freq_q  <= 16'h0000;
      end else begin
         tc_q    <= tc_d;
         tick_q  <= tick_d;
         tm_q    <= tm_d;
         init_q  <= init_d;
         st_q    <= st_d;
         dir_q   <= dir_d;
         on_q    <= on_d;
         slp_o_q <= slp_o_d;
         freq_q  <= freq_d;
      end
   end

   assign FREQ_CMD  = freq_q;
   assign DIR_REV   = dir_q;
   assign OUTPUT_ON = on_q;
   assign SLEEPING  = slp_o_q;

endmodule

// >>> logic/drs_regs.svh
// Register map, field positions, reset values and timing counts
// for the run sequencer. Included by the top module and the testbench.
`ifndef DRS_REGS_SVH
`define DRS_REGS_SVH

`define DRS_A_CFG       8'h00
`define DRS_A_DEADZONE  8'h04
`define DRS_A_STOP_THR  8'h08
`define DRS_A_STOP_TIME 8'h0C
`define DRS_A_WAKE      8'h10
`define DRS_A_RESTART   8'h14
`define DRS_A_SLEEP     8'h18
`define DRS_A_SET_FREQ  8'h1C
`define DRS_A_LOW_LIM   8'h20
`define DRS_A_START_F   8'h24
`define DRS_A_STATUS    8'h28

`define DRS_F_SW_SEL    1:0
`define DRS_F_SRC_SEL   2
`define DRS_F_PROTECT   3
`define DRS_F_LIM_ACT   5:4
`define DRS_F_RESTART   6
`define DRS_F_TERM_CTRL 7
`define DRS_F_OVM       8
`define DRS_F_SOFT_RUN  9
`define DRS_F_SOFT_REV  10

`define DRS_R_CFG       11'h001
`define DRS_R_DEADZONE  16'h0000
`define DRS_R_STOP_THR  16'h0032
`define DRS_R_STOP_TIME 16'h0032
`define DRS_R_WAKE      16'h0000
`define DRS_R_RESTART   16'h000A
`define DRS_R_SLEEP     16'h0000
`define DRS_R_ZERO16    16'h0000

`define DRS_TICK_NS     10000000
`define DRS_CLK_NS      40
`define DRS_TICK_CYCLES (`DRS_TICK_NS / `DRS_CLK_NS)
`define DRS_TENTH_TICKS 20'h0000A
`define DRS_INIT_CYCLES 3'h5

`endif

// >>> logic/drs_pkg.sv
// Types shared by the run sequencer.
// Assumes drs_regs.svh for field layout.
package drs_pkg;
   typedef struct packed {
      logic       soft_rev;
      logic       soft_run;
      logic       ovm;
      logic       term_ctrl;
      logic       restart_en;
      logic [1:0] lim_act;
      logic       protect;
      logic       src_sel;
      logic [1:0] sw_sel;
   } drs_cfg_t;

   typedef enum logic [3:0] {
      S_INIT, S_RESTART_WAIT, S_PROTECT, S_STOP, S_RUN,
      S_REV_HOLD, S_DEADZONE, S_LIM_STOP, S_SLEEP_PEND, S_SLEEP
   } drs_state_t;
endpackage

// >>> verif/drs_chk.sv
// Port assertions for the run sequencer, bound into drs_top.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/100ps
module drs_chk (
   input logic        CLOCK,
   input logic        RST_N,
   input logic        AWVALID,
   input logic        AWREADY,
   input logic        WVALID,
   input logic        WREADY,
   input logic [1:0]  BRESP,
   input logic        BVALID,
   input logic        BREADY,
   input logic [7:0]  ARADDR,
   input logic        ARVALID,
   input logic        ARREADY,
   input logic [31:0] RDATA,
   input logic [1:0]  RRESP,
   input logic        RVALID,
   input logic        RREADY,
   input logic [15:0] FREQ_CMD,
   input logic        DIR_REV,
   input logic        OUTPUT_ON,
   input logic        SLEEPING
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   a_off_no_freq: assert property (!OUTPUT_ON |-> FREQ_CMD == 16'h0)
      else $error("frequency requested with output off");
   a_sleep_idle: assert property (SLEEPING |-> !OUTPUT_ON && FREQ_CMD == 16'h0)
      else $error("output driven while asleep");
   // Reversal under drive only after a held level
   a_rev_held: assert property (OUTPUT_ON && $changed(DIR_REV)
      |-> $past(FREQ_CMD, 2) == $past(FREQ_CMD))
      else $error("direction flipped without hold");
   a_b_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
      else $error("write response missing");
   a_b_stands: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped");
   a_r_answer: assert property (ARVALID && ARREADY |=> RVALID)
      else $error("read data missing");
   a_r_stands: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
      else $error("read data dropped");
   a_ar_blocked: assert property (RVALID |-> !ARREADY)
      else $error("read address accepted while data pending");
   a_unmapped_rd: assert property (ARVALID && ARREADY && ARADDR > 8'h28
      |=> RRESP == 2'h2 && RDATA == 32'h0)
      else $error("unmapped read not refused");

   cover property ($rose(SLEEPING));
   cover property (OUTPUT_ON && $changed(DIR_REV));
   cover property (BVALID && BRESP == 2'h2);
   cover property ($fell(OUTPUT_ON));
endmodule

bind drs_top drs_chk u_chk (
   .CLOCK(CLOCK), .RST_N(RST_N), .AWVALID(AWVALID), .AWREADY(AWREADY),
   .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
   .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
   .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .FREQ_CMD(FREQ_CMD),
   .DIR_REV(DIR_REV), .OUTPUT_ON(OUTPUT_ON), .SLEEPING(SLEEPING));

// >>> verif/drs_mtr.sv
// Far side: run terminals and a motor whose speed follows the request.
// Assumes the bench sets wanted terminal levels; speed slews 64 per cycle.
`timescale 1ns/100ps
module drs_mtr (
   input  logic        clk,
   input  logic        rst_n,
   input  logic        want_fwd,
   input  logic        want_rev,
   input  logic [15:0] freq,
   output logic        run_fwd,
   output logic        run_rev,
   output logic [15:0] speed_fb
);
   // Terminals are asynchronous pins, so skew them off the edge
   assign #7 run_fwd = want_fwd;
   assign #7 run_rev = want_rev;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         speed_fb <= 16'h0;
      end else if (speed_fb < freq) begin
         speed_fb <= (freq - speed_fb > 16'h40) ? speed_fb + 16'h40 : freq;
      end else begin
         speed_fb <= (speed_fb - freq > 16'h40) ? speed_fb - 16'h40 : freq;
      end
   end
endmodule

// >>> verif/drs_tb.sv
// Self-checking bench for the run sequencer over AXI4-Lite.
// Assumes drs_top, drs_mtr and the checker bind are compiled first.
`timescale 1ns/100ps
`include "drs_regs.svh"
module testbench;
   import drs_pkg::*;
   localparam int LOW = 100;
   localparam int STF = 50;
   localparam logic [31:0] RV [7] = '{32'h1, 32'h0, 32'h32, 32'h32, 32'h0, 32'hA, 32'h0};
   logic        CLOCK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
   logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, RUN_FWD, RUN_REV;
   logic        DIR_REV, OUTPUT_ON, SLEEPING, want_fwd, want_rev, rv;
   logic [7:0]  AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA, d;
   logic [3:0]  WSTRB;
   logic [1:0]  BRESP, RRESP, r;
   logic [15:0] SPEED_FB, FREQ_CMD;
   logic [15:0] lfsr = 16'hBD68;
   int          n_errors, n_tests, cyc, set;

   drs_top #(.TICK_CYCLES(4)) DUT (
      .CLOCK(CLOCK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
      .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
      .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
      .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
      .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .RUN_FWD(RUN_FWD),
      .RUN_REV(RUN_REV), .SPEED_FB(SPEED_FB), .FREQ_CMD(FREQ_CMD),
      .DIR_REV(DIR_REV), .OUTPUT_ON(OUTPUT_ON), .SLEEPING(SLEEPING));
   drs_mtr u_mtr (
      .clk(CLOCK), .rst_n(RST_N), .want_fwd(want_fwd), .want_rev(want_rev),
      .freq(FREQ_CMD), .run_fwd(RUN_FWD), .run_rev(RUN_REV), .speed_fb(SPEED_FB));

   initial begin
      CLOCK = 1'b0;
      forever #20 CLOCK = ~CLOCK;
   end

   function automatic int rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return 200 + lfsr[11:0];
   endfunction
   function automatic logic [31:0] cfg(int sw, logic v);
      return 32'(sw) | 32'h200 | (sw == 2 ? 32'h4 : 32'h0) | {21'h0, v, 10'h0};
   endfunction
   // Model of the steady outputs {sleeping, on, dir, freq}
   function automatic logic [18:0] exp_out(int s, int act, logic v);
      if (s >= LOW) return {2'b01, v, 16'(s)};
      if (act == 0) return {2'b01, v, 16'(LOW)};
      if (act == 1) return 19'h0;
      return {2'b10, 17'h0};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input int got, input int lo, input int hi);
      n_tests++;
      if (got < lo || got > hi) begin
         n_errors++;
         $display("ERROR t=%0t cycles=%h range=%h..%h", $time, got, lo, hi);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      @(posedge CLOCK);
      AWADDR <= a;
      WDATA <= v;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      do begin
         @(posedge CLOCK);
         if (AWREADY) AWVALID <= 1'b0;
         if (WREADY) WVALID <= 1'b0;
      end while (!BVALID);
      BREADY <= 1'b0;
      chk({30'h0, BRESP}, {30'h0, er});
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
      @(posedge CLOCK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do begin
         @(posedge CLOCK);
         if (ARREADY) ARVALID <= 1'b0;
      end while (!RVALID);
      v = RDATA;
      rr = RRESP;
      RREADY <= 1'b0;
   endtask
   // Power cut with the forward terminal held, config written before init ends
   task automatic power_on(input logic [31:0] c);
      want_fwd <= 1'b1;
      RST_N <= 1'b0;
      repeat (4) @(posedge CLOCK);
      RST_N <= 1'b1;
      wr(`DRS_A_CFG, c, 2'h0);
   endtask
   task automatic wait_out(input logic [18:0] e, input int lim, output int n);
      n = 0;
      while ({SLEEPING, OUTPUT_ON, DIR_REV, FREQ_CMD} !== e && n < lim) begin
         @(posedge CLOCK);
         n++;
      end
      chk({13'h0, SLEEPING, OUTPUT_ON, DIR_REV, FREQ_CMD}, {13'h0, e});
   endtask
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Longest path is about a thousand cycles
   initial begin
      repeat (20000) @(posedge CLOCK);
      n_errors++;
      stop_test();
   end

   initial begin
      RST_N = 1'b0;
      AWVALID = 1'b0;
      WVALID = 1'b0;
      BREADY = 1'b0;
      ARVALID = 1'b0;
      RREADY = 1'b0;
      AWADDR = 8'h0;
      ARADDR = 8'h0;
      WDATA = 32'h0;
      WSTRB = 4'hF;
      want_fwd = 1'b0;
      want_rev = 1'b0;
      repeat (4) @(posedge CLOCK);
      RST_N <= 1'b1;
      repeat (2) @(posedge CLOCK);
      for (int i = 0; i < 7; i++) begin
         rd(8'(4 * i), d, r);
         chk(d, RV[i]);
      end
      rd(8'h2C, d, r);
      chk({r, d[29:0]}, 32'h80000000);
      wr(8'h2C, 32'h1, 2'h2);
      rd(`DRS_A_STATUS, d, r);
      chk({28'h0, d[3:0]}, 32'h3);
      $display("Register defaults done");

      wr(`DRS_A_LOW_LIM, LOW, 2'h0);
      wr(`DRS_A_START_F, STF, 2'h0);
      wr(`DRS_A_DEADZONE, 32'h1, 2'h0);
      wr(`DRS_A_STOP_TIME, 32'h2, 2'h0);
      wr(`DRS_A_WAKE, 32'h1, 2'h0);
      wr(`DRS_A_SLEEP, 32'h1, 2'h0);
      rv = 1'b0;
      for (int sw = 0; sw < 3; sw++) begin
         set = rnd();
         wr(`DRS_A_SET_FREQ, set, 2'h0);
         wr(`DRS_A_CFG, cfg(sw, rv), 2'h0);
         wait_out(exp_out(set, 0, rv), 400, cyc);
         rv = ~rv;
         wr(`DRS_A_CFG, cfg(sw, rv), 2'h0);
         wait_out({2'b01, ~rv, (sw == 1) ? 16'(STF) : 16'h0}, 100, cyc);
         cyc = 0;
         while (DIR_REV !== rv && cyc < 300) begin
            @(posedge CLOCK);
            cyc++;
         end
         chk_rng(cyc, 36, 150);
         wait_out(exp_out(set, 0, rv), 100, cyc);
      end
      $display("Reversal done");

      rv = 1'b0;
      for (int act = 0; act < 3; act++) begin
         wr(`DRS_A_CFG, cfg(1, rv) | (32'(act) << 4), 2'h0);
         wr(`DRS_A_SET_FREQ, 32'h32, 2'h0);
         wait_out(exp_out(STF, act, rv), 400, cyc);
         if (act == 2) chk_rng(cyc, 36, 60);
         set = rnd();
         wr(`DRS_A_SET_FREQ, set, 2'h0);
         wait_out(exp_out(set, act, rv), 400, cyc);
         chk_rng(cyc, act == 2 ? 36 : 0, act == 2 ? 60 : 8);
      end
      $display("Lower limit done");

      wr(`DRS_A_CFG, 32'h81, 2'h0);
      want_rev <= 1'b1;
      wait_out({3'b011, 16'(set)}, 400, cyc);
      rd(`DRS_A_STATUS, d, r);
      chk({30'h0, d[8:7]}, 32'h2);
      want_rev <= 1'b0;
      want_fwd <= 1'b1;
      wait_out({3'b010, 16'(set)}, 400, cyc);
      want_fwd <= 1'b0;
      wait_out(19'h0, 100, cyc);
      $display("Terminal control done");

      power_on(32'h80);
      repeat (4) @(posedge CLOCK);
      rd(`DRS_A_STATUS, d, r);
      chk({28'h0, d[3:0]}, 32'h2);
      wait_out(19'h0, 0, cyc);
      want_fwd <= 1'b0;
      repeat (8) @(posedge CLOCK);
      want_fwd <= 1'b1;
      wait_out({3'b010, 16'h0}, 40, cyc);
      power_on(32'h88);
      wait_out({3'b010, 16'h0}, 40, cyc);
      power_on(32'hC0);
      wait_out({3'b010, 16'h0}, 600, cyc);
      chk_rng(cyc, 390, 420);
      want_fwd <= 1'b0;
      wait_out(19'h0, 100, cyc);
      $display("Power-on done");
      stop_test();
   end
endmodule
